// ---- hw/adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;
    // Clock rate in MHz and documented times
    localparam int CLK_MHZ = 50;
    localparam int ARM_PULSE_NS = 1500;
    localparam int CONV_TIME_NS = 4500;
    localparam int BUSY_DELAY_NS = 30;
    // Every time rounds down to whole cycles, least times included
    localparam int ARM_CYCLES = (ARM_PULSE_NS * CLK_MHZ) / 1000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
    localparam int BUSY_DELAY_CYCLES = (BUSY_DELAY_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] RESULT_RST = 8'h00;

    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'b00,
        ST_IDLE = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;
endpackage

// ---- hw/result_store.sv ----
`timescale 1ns/1ps
// Holds one result word; read data comes from a register
module result_store #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    // Read side
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_q;
    logic [WIDTH-1:0] mem_d;

    // Keep last completed value until the next write
    always_comb
    begin
        mem_d = wr_en ? wr_data : mem_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mem_q <= '0;
        else
            mem_q <= mem_d;
    end

    assign rd_data = mem_q;
endmodule

// ---- hw/adc_conversion_parallel_read.sv ----
`timescale 1ns/1ps
module adc_conversion_parallel_read #(
    parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYCLES,
    parameter int ARM_CYCLES = adc_ctrl_pkg::ARM_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Conversion control pins
    input wire logic convert_start_n,
    output logic busy,
    // Host read pins
    input wire logic chip_select_n,
    input wire logic read_n,
    output logic [7:0] data_out_bus,
    output logic [7:0] data_out_bus_oe,
    // Converter core side
    input wire logic [7:0] sample_code,
    output logic powered,
    output logic tracking
);
    // Counters are CNT_W bits wide; refuse counts they cannot hold
    if (CONV_CYCLES < 2 || CONV_CYCLES > 255 || ARM_CYCLES < 1 || ARM_CYCLES > 255)
    begin : g_bad_counts
        $error("cycle counts out of range");
    end

    // Three-stage synchronisers; change counts when stages 2 and 3 agree
    logic [2:0] cs_sync_q, cs_sync_d;
    logic [2:0] csel_sync_q, csel_sync_d;
    logic [2:0] rd_sync_q, rd_sync_d;
    logic conv_lvl_q, conv_lvl_d;
    logic csel_lvl_q, csel_lvl_d;
    logic rd_lvl_q, rd_lvl_d;

    always_comb
    begin
        cs_sync_d = {cs_sync_q[1:0], convert_start_n};
        csel_sync_d = {csel_sync_q[1:0], chip_select_n};
        rd_sync_d = {rd_sync_q[1:0], read_n};
        conv_lvl_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : conv_lvl_q;
        csel_lvl_d = (csel_sync_q[1] == csel_sync_q[2]) ? csel_sync_q[2] : csel_lvl_q;
        rd_lvl_d = (rd_sync_q[1] == rd_sync_q[2]) ? rd_sync_q[2] : rd_lvl_q;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cs_sync_q <= 3'h7;
            csel_sync_q <= 3'h7;
            rd_sync_q <= 3'h7;
            conv_lvl_q <= 1'b1;
            csel_lvl_q <= 1'b1;
            rd_lvl_q <= 1'b1;
        end
        else
        begin
            cs_sync_q <= cs_sync_d;
            csel_sync_q <= csel_sync_d;
            rd_sync_q <= rd_sync_d;
            conv_lvl_q <= conv_lvl_d;
            csel_lvl_q <= csel_lvl_d;
            rd_lvl_q <= rd_lvl_d;
        end
    end

    logic conv_rise;
    logic conv_fall;
    assign conv_rise = conv_lvl_d & ~conv_lvl_q;
    assign conv_fall = ~conv_lvl_d & conv_lvl_q;

    // Arming pulse: low while counter runs
    logic [adc_ctrl_pkg::CNT_W-1:0] arm_cnt_q, arm_cnt_d;
    logic arm_low;
    assign arm_low = (arm_cnt_q != '0);

    always_comb
    begin
        arm_cnt_d = arm_cnt_q;
        if (conv_rise)
            arm_cnt_d = adc_ctrl_pkg::CNT_W'(ARM_CYCLES);
        else if (arm_low)
            arm_cnt_d = arm_cnt_q - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            arm_cnt_q <= '0;
        else
            arm_cnt_q <= arm_cnt_d;
    end

    // Conversion state machine
    adc_ctrl_pkg::conv_state_t state_q, state_d;
    logic [adc_ctrl_pkg::CNT_W-1:0] conv_cnt_q, conv_cnt_d;
    logic busy_q, busy_d;
    logic powered_q, powered_d;
    logic tracking_q, tracking_d;
    logic done;

    always_comb
    begin
        state_d = state_q;
        conv_cnt_d = conv_cnt_q;
        busy_d = busy_q;
        powered_d = powered_q;
        tracking_d = tracking_q;
        done = 1'b0;
        unique case (state_q)
            adc_ctrl_pkg::ST_POWER_DOWN:
            begin
                // Power comes up on the rise, well inside the arming pulse
                if (conv_rise)
                begin
                    powered_d = 1'b1;
                    state_d = adc_ctrl_pkg::ST_IDLE;
                end
            end
            adc_ctrl_pkg::ST_IDLE:
            begin
                if (conv_fall && arm_low)
                begin
                    state_d = adc_ctrl_pkg::ST_CONVERT;
                    conv_cnt_d = adc_ctrl_pkg::CNT_W'(CONV_CYCLES - 1);
                    busy_d = 1'b1;
                    tracking_d = 1'b0;
                end
            end
            adc_ctrl_pkg::ST_CONVERT:
            begin
                if (conv_cnt_q == '0)
                begin
                    done = 1'b1;
                    busy_d = 1'b0;
                    tracking_d = 1'b1;
                    // Low level at the end selects automatic power-down
                    powered_d = conv_lvl_q;
                    state_d = conv_lvl_q ? adc_ctrl_pkg::ST_IDLE
                                         : adc_ctrl_pkg::ST_POWER_DOWN;
                end
                else
                    conv_cnt_d = conv_cnt_q - 1'b1;
            end
            default:
                state_d = adc_ctrl_pkg::ST_POWER_DOWN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= adc_ctrl_pkg::ST_POWER_DOWN;
            conv_cnt_q <= '0;
            busy_q <= 1'b0;
            powered_q <= 1'b0;
            tracking_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            conv_cnt_q <= conv_cnt_d;
            busy_q <= busy_d;
            powered_q <= powered_d;
            tracking_q <= tracking_d;
        end
    end

    // Result held until the next completion
    logic [7:0] result;
    result_store #(
        .WIDTH(adc_ctrl_pkg::DATA_W)
    ) u_store (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(done),
        .wr_data(sample_code),
        .rd_data(result)
    );

    // Bus drive; outputs registered so bus lags strobes by the sync delay
    logic [7:0] dout_q, dout_d;
    logic [7:0] oe_q, oe_d;

    always_comb
    begin
        oe_d = {8{~csel_lvl_d & ~rd_lvl_d}};
        dout_d = oe_d[0] ? result : 8'h00;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dout_q <= 8'h00;
            oe_q <= 8'h00;
        end
        else
        begin
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    assign busy = busy_q;
    assign powered = powered_q;
    assign tracking = tracking_q;
    assign data_out_bus = dout_q;
    assign data_out_bus_oe = oe_q;
endmodule

// ---- sim/adc_conversion_parallel_read_chk.sv ----
`timescale 1ns/1ps
module adc_chk #(
    parameter int CONV_CYCLES = 8,
    parameter int ARM_CYCLES = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Conversion pins
    input wire logic convert_start_n,
    input wire logic busy,
    // Read pins
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic [7:0] data_out_bus,
    input wire logic [7:0] data_out_bus_oe,
    // Core side
    input wire logic [7:0] sample_code,
    input wire logic powered,
    input wire logic tracking
);
    logic [7:0] run_q;
    logic [7:0] run_d;
    // Busy run length; a counter avoids a long repetition
    always_comb run_d = busy ? run_q + 8'h01 : 8'h00;
    always_ff @(posedge clk) run_q <= rst_n ? run_d : 8'h00;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_busy_width: assert property ($fell(busy) |-> run_q == 8'(CONV_CYCLES))
        else $error("busy width wrong");
    a_bus_off: assert property ((chip_select_n || read_n) [*6] |=> data_out_bus_oe == 8'h00)
        else $error("bus driven without strobes");
    a_bus_on: assert property ((!chip_select_n && !read_n) [*6] |=> data_out_bus_oe == 8'hFF)
        else $error("bus not driven on read");
    a_result_hold: assert property (data_out_bus_oe == 8'hFF && $past(data_out_bus_oe) == 8'hFF
        && !busy && !$past(busy, 3) |-> $stable(data_out_bus))
        else $error("result moved during read");
    a_track_busy: assert property (tracking == !busy)
        else $error("tracking not opposite busy");
    a_busy_cause: assert property ($rose(busy) |-> !$past(convert_start_n, 3) && powered)
        else $error("busy without start");
    a_wake_up: assert property ($rose(convert_start_n) && !powered |-> ##[1:75] powered)
        else $error("no power up");
    a_power_end: assert property ($fell(busy) |-> powered == convert_start_n)
        else $error("power state at end wrong");
endmodule
bind adc_conversion_parallel_read adc_chk #(.CONV_CYCLES(CONV_CYCLES), .ARM_CYCLES(ARM_CYCLES))
    chk (.clk, .rst_n, .convert_start_n, .busy, .chip_select_n, .read_n, .data_out_bus,
    .data_out_bus_oe, .sample_code, .powered, .tracking);

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clk,
    // Conversion pins
    input wire logic busy,
    output logic convert_start_n,
    // Read pins
    output logic chip_select_n,
    output logic read_n,
    input wire logic [7:0] data_out_bus,
    input wire logic [7:0] data_out_bus_oe
);
    // Pins idle high, as reset expects
    initial
    begin
        convert_start_n = 1'b1;
        chip_select_n = 1'b1;
        read_n = 1'b1;
    end
    // Low, rise, then fall after gap cycles
    task automatic pulse(input int gap);
        repeat (5) @(negedge clk);
        convert_start_n = 1'b0;
        repeat (8) @(negedge clk);
        convert_start_n = 1'b1;
        repeat (gap) @(negedge clk);
        convert_start_n = 1'b0;
    endtask
    // Level at the end picks power-down or staying up
    task automatic convert(input logic stay);
        pulse(2);
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        convert_start_n = stay;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
    endtask
    // Strobe held past the answer so the bus is seen settled
    task automatic read(output logic [7:0] value);
        chip_select_n = 1'b0;
        read_n = 1'b0;
        for (int i = 0; i < 10 && data_out_bus_oe !== 8'hFF; i++) @(negedge clk);
        value = (data_out_bus_oe === 8'hFF) ? data_out_bus : 8'hXX;
        repeat (6) @(negedge clk);
        chip_select_n = 1'b1;
        read_n = 1'b1;
        for (int i = 0; i < 10 && data_out_bus_oe !== 8'h00; i++) @(negedge clk);
    endtask
endmodule

// ---- sim/adc_conversion_parallel_read_test.sv ----
`timescale 1ns/1ps
module adc_conversion_parallel_read_test;
    logic clk, rst_n, convert_start_n, busy, chip_select_n, read_n, powered, tracking, seen;
    logic [7:0] data_out_bus, data_out_bus_oe, sample_code, rd_val;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Short counts keep the run brief
    adc_conversion_parallel_read #(.CONV_CYCLES(8), .ARM_CYCLES(4)) dut (.clk, .rst_n,
        .convert_start_n, .busy, .chip_select_n, .read_n, .data_out_bus, .data_out_bus_oe,
        .sample_code, .powered, .tracking);
    host_model host (.clk, .busy, .convert_start_n, .chip_select_n, .read_n, .data_out_bus,
        .data_out_bus_oe);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_reset;
        chk("busy", busy, 8'h00);
        chk("powered", powered, 8'h00);
        chk("oe", data_out_bus_oe, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_power_down;
        sample_code = 8'hA5;
        host.convert(1'b0);
        chk("busy", busy, 8'h00);
        chk("powered", powered, 8'h00);
        chk("tracking", tracking, 8'h01);
        host.read(rd_val);
        chk("data", rd_val, 8'hA5);
        chk("oe", data_out_bus_oe, 8'h00);
        $display("power-down test done");
    endtask
    task automatic t_stay;
        sample_code = 8'h3C;
        host.convert(1'b1);
        chk("powered", powered, 8'h01);
        sample_code = 8'h5A;
        host.read(rd_val);
        chk("data", rd_val, 8'h3C);
        host.read(rd_val);
        chk("data", rd_val, 8'h3C);
        $display("stay-powered test done");
    endtask
    // Fall long after the arming window must be ignored
    task automatic t_refused;
        seen = 1'b0;
        host.pulse(12);
        repeat (20)
        begin
            @(negedge clk);
            seen = seen | busy;
        end
        chk("late start", seen, 8'h00);
        host.read(rd_val);
        chk("data", rd_val, 8'h3C);
        $display("refused start test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        sample_code = 8'h00;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_power_down();
        t_stay();
        t_refused();
        print_verdict();
    end
endmodule
